/* hdl/port_e_io.sv */
// Four-pin port with direction, latch, client strobes and APB registers
`timescale 1ns/10ps
`default_nettype none

module port_e_io #(
    parameter int FULL_PORT = 1,
    parameter int DATA_W    = 8
) (
    input  wire logic              pclk,          // APB clock, 100 MHz
    input  wire logic              presetn,       // Async reset, low
    input  wire logic              psel,          // APB select
    input  wire logic              penable,       // APB access phase
    input  wire logic              pwrite,        // APB direction
    input  wire logic [7:0]        paddr,         // APB byte address
    input  wire logic [31:0]       pwdata,        // APB write data
    output logic [31:0]            prdata,        // APB read data
    output logic                   pready,        // APB ready
    output logic                   pslverr,       // APB error
    input  wire logic [2:0]        pin_in,        // Pin levels, pins 0..2
    output logic [2:0]             pin_out,       // Pin drive values
    output logic [2:0]             pin_oe,        // Pin drive enables
    input  wire logic [2:0]        analog_sel,    // Analog select per pin
    input  wire logic              input_only_pin,         // Fourth pin level
    input  wire logic              master_clear_pin_select, // Config setting
    output logic                   master_clear_n,         // Master clear, low
    input  wire logic [DATA_W-1:0] client_data_in,         // Client bus in
    output logic [DATA_W-1:0]      client_data_out,        // Client bus out
    output logic                   client_data_oe,         // Client bus drive
    output logic                   irq                     // Interrupt level
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (DATA_W != 8) begin : g_bad_width
            $error("port_e_io: DATA_W must be 8");
        end
        if (FULL_PORT != 0 && FULL_PORT != 1) begin : g_bad_variant
            $error("port_e_io: FULL_PORT must be 0 or 1");
        end
    endgenerate

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [2:0]                dir_reg;
    logic [2:0]                dir_next;
    logic [2:0]                latch_reg;
    logic [2:0]                latch_next;
    logic                      client_en_reg;
    logic                      client_en_next;
    logic                      in_full_reg;
    logic                      in_full_next;
    logic                      out_pend_reg;
    logic                      out_pend_next;
    logic                      overrun_reg;
    logic                      overrun_next;
    logic [DATA_W-1:0]         in_word_reg;
    logic [DATA_W-1:0]         in_word_next;
    logic [DATA_W-1:0]         out_word_reg;
    logic [DATA_W-1:0]         out_word_next;
    logic [port_e_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [port_e_pkg::IRQ_W-1:0] irq_stat_next;
    logic [port_e_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [port_e_pkg::IRQ_W-1:0] irq_mask_next;
    logic [31:0]               rdata_reg;
    logic [31:0]               rdata_next;
    logic                      late_word_reg;
    logic                      late_word_next;
    logic                      oe_drive_reg;
    logic                      oe_drive_next;
    port_e_pkg::client_e       state_reg;
    port_e_pkg::client_e       state_next;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire setup    = psel & ~penable;
    wire access   = psel & penable;
    wire wr_xfer  = access & pwrite;
    wire rd_xfer  = access & ~pwrite;
    wire hit_pin  = (paddr == port_e_pkg::ADDR_PIN_DATA);
    wire hit_lat  = (paddr == port_e_pkg::ADDR_LATCH);
    wire hit_dir  = (paddr == port_e_pkg::ADDR_DIR_STAT);
    wire hit_in   = (paddr == port_e_pkg::ADDR_IN_WORD);
    wire hit_out  = (paddr == port_e_pkg::ADDR_OUT_WORD);
    wire hit_ist  = (paddr == port_e_pkg::ADDR_IRQ_STAT);
    wire hit_imk  = (paddr == port_e_pkg::ADDR_IRQ_MASK);
    wire hit_any  = hit_pin | hit_lat | hit_dir | hit_in | hit_out | hit_ist | hit_imk;
    wire wr_latch = wr_xfer & (hit_pin | hit_lat);
    wire wr_dir   = wr_xfer & hit_dir;
    wire wr_out   = wr_xfer & hit_out;
    wire wr_imk   = wr_xfer & hit_imk;
    wire rd_in    = rd_xfer & hit_in;
    wire rd_ist   = rd_xfer & hit_ist;

    // ------------------------------------------------------------
    // Pin paths
    // ------------------------------------------------------------
    wire full_port = (FULL_PORT != 0);

    // Converter logic owns the analog select and resets it to all-analog
    wire [2:0] analog_eff = full_port ? analog_sel : 3'h7;

    // Digital input path gated off under analog selection
    wire [2:0] pin_digital = pin_in & ~analog_eff;

    // Fourth pin is data only with master clear disabled
    wire fourth_pin_bit = ~master_clear_pin_select & input_only_pin;

    // Pins 0..2 read zero in the reduced variant
    wire [2:0] low_pins = full_port ? pin_digital : 3'h0;

    wire [7:0] pin_data_view = {4'h0, fourth_pin_bit, low_pins};

    wire [7:0] dir_stat_view = {in_full_reg, out_pend_reg, overrun_reg,
                                client_en_reg, 1'b0, dir_reg};

    // Driver follows direction only; analog select cannot override it
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            assign pin_oe[gi]  = full_port & ~dir_reg[gi];
            assign pin_out[gi] = latch_reg[gi];
        end
    endgenerate

    // Master clear asserted only while the pin is configured for it
    assign master_clear_n = ~master_clear_pin_select | input_only_pin;

    // ------------------------------------------------------------
    // Client strobes
    // ------------------------------------------------------------
    // Strobes use the raw pin level; converter config keeps them digital
    port_e_pkg::strobe_s strobe;
    assign strobe.rd_n = pin_in[port_e_pkg::BIT_RD_STROBE];
    assign strobe.wr_n = pin_in[port_e_pkg::BIT_WR_STROBE];
    assign strobe.cs_n = pin_in[port_e_pkg::BIT_CS_STROBE];

    // Strobes only count while every strobe pin is an input
    wire client_live = full_port & client_en_reg & (&dir_reg);
    wire wr_low      = client_live & ~strobe.cs_n & ~strobe.wr_n;
    wire rd_low      = client_live & ~strobe.cs_n & ~strobe.rd_n;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            port_e_pkg::ST_IDLE: begin
                if (wr_low) begin
                    state_next = port_e_pkg::ST_WRITE;
                end else if (rd_low) begin
                    state_next = port_e_pkg::ST_READ;
                end
            end
            port_e_pkg::ST_WRITE: begin
                if (!wr_low) begin
                    state_next = port_e_pkg::ST_IDLE;
                end
            end
            port_e_pkg::ST_READ: begin
                if (!rd_low) begin
                    state_next = port_e_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = port_e_pkg::ST_IDLE;
            end
        endcase
    end

    wire in_write   = (state_reg == port_e_pkg::ST_WRITE);
    wire in_read    = (state_reg == port_e_pkg::ST_READ);
    wire idle       = (state_reg == port_e_pkg::ST_IDLE);
    wire write_end  = in_write & ~wr_low;
    wire read_start = idle & ~wr_low & rd_low;
    wire read_end   = in_read & ~rd_low;
    wire read_busy  = read_start | (in_read & rd_low);

    // ------------------------------------------------------------
    // Next-state logic for registers
    // ------------------------------------------------------------
    assign latch_next = wr_latch ? pwdata[2:0] : latch_reg;

    assign dir_next = wr_dir ? pwdata[2:0] : dir_reg;

    assign client_en_next = wr_dir ? pwdata[port_e_pkg::BIT_CLIENT_EN]
                                   : client_en_reg;

    // Word landing after the read captured its data must stay flagged
    assign late_word_next = setup & ~pwrite & hit_in & write_end;

    // Incoming word sets the flag; the processor read clears it; set wins
    assign in_full_next = write_end ? 1'b1
                        : ((rd_in & ~late_word_reg) ? 1'b0
                        : in_full_reg);

    // Word written while a read is underway goes straight out unflagged
    assign out_pend_next = read_start ? 1'b0
                         : ((wr_out & ~read_busy) ? 1'b1
                         : out_pend_reg);

    // Software may only clear the overrun flag; a new overrun wins
    assign overrun_next = (write_end & in_full_reg) ? 1'b1
                        : ((wr_dir & ~pwdata[port_e_pkg::BIT_OVERRUN])
                           ? 1'b0 : overrun_reg);

    assign in_word_next  = write_end ? client_data_in : in_word_reg;
    assign out_word_next = wr_out ? pwdata[DATA_W-1:0] : out_word_reg;

    // Bus drive is registered so the data output comes from a flip-flop
    assign oe_drive_next = read_busy & state_next == port_e_pkg::ST_READ;

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    logic [port_e_pkg::IRQ_W-1:0] irq_event;
    assign irq_event[port_e_pkg::IRQ_WRITE_DONE] = write_end;
    assign irq_event[port_e_pkg::IRQ_READ_DONE]  = read_end;
    assign irq_event[port_e_pkg::IRQ_OVERRUN]    = write_end & in_full_reg;

    // Read clears only the bits it returned; later events survive
    assign irq_stat_next = irq_event
                         | (rd_ist ? (irq_stat_reg & ~rdata_reg[port_e_pkg::IRQ_W-1:0])
                                   : irq_stat_reg);
    assign irq_mask_next = wr_imk ? pwdata[port_e_pkg::IRQ_W-1:0] : irq_mask_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // Read data, sampled in the setup cycle
    // ------------------------------------------------------------
    wire [31:0] rd_mux =
        hit_pin ? {24'h0, pin_data_view} :
        hit_lat ? {29'h0, latch_reg} :
        hit_dir ? {24'h0, dir_stat_view} :
        hit_in  ? {24'h0, in_word_reg} :
        hit_out ? {24'h0, out_word_reg} :
        hit_ist ? {29'h0, irq_stat_reg} :
        hit_imk ? {29'h0, irq_mask_reg} : 32'h0;

    assign rdata_next = (setup & ~pwrite) ? rd_mux : rdata_reg;

    assign prdata  = rdata_reg;
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;

    assign client_data_out = out_word_reg;
    assign client_data_oe  = oe_drive_reg;

    // ------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_reg       <= port_e_pkg::DIR_RESET;
            latch_reg     <= port_e_pkg::LATCH_RESET;
            client_en_reg <= 1'b0;
        end else begin
            dir_reg       <= dir_next;
            latch_reg     <= latch_next;
            client_en_reg <= client_en_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_full_reg   <= 1'b0;
            out_pend_reg  <= 1'b0;
            overrun_reg   <= 1'b0;
            late_word_reg <= 1'b0;
        end else begin
            in_full_reg   <= in_full_next;
            out_pend_reg  <= out_pend_next;
            overrun_reg   <= overrun_next;
            late_word_reg <= late_word_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_word_reg  <= port_e_pkg::WORD_RESET;
            out_word_reg <= port_e_pkg::WORD_RESET;
            oe_drive_reg <= 1'b0;
            state_reg    <= port_e_pkg::ST_IDLE;
        end else begin
            in_word_reg  <= in_word_next;
            out_word_reg <= out_word_next;
            oe_drive_reg <= oe_drive_next;
            state_reg    <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= port_e_pkg::IRQ_RESET;
            irq_mask_reg <= port_e_pkg::IRQ_RESET;
            rdata_reg    <= 32'h0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg    <= rdata_next;
        end
    end

endmodule

`default_nettype wire

/* hdl/port_e_pkg.sv */
// Constants, types and register map of the four-pin port block
// How it works
// - Direction bit one floats the pin driver; zero drives the latched value.
// - Data reads return zero for a pin selected as analog input.
// - Direction bits drive enables even for analog pins; software keeps them inputs.
// - After power-on the three lower pins default to analog inputs.
// - Latch reads return latch contents; writes update the latch.
// - Fourth pin is input only: digital input or master clear per config.
// - Analog selection leaves output drive alone but disables digital input.
// - Control resets direction bits to one, upper bits to zero; bit 3 reads zero.
// - Bit 7 flags a received word not yet read by the processor.
// - Bit 6 flags an output word not yet read by the external party.
// - Bit 5 sets on a write over an unread word; software clears it.
// - Bit 4 selects client port mode when one, plain I/O when zero.
// - In client mode pin 0 is read strobe, pin 1 write strobe.
// - In client mode pin 2 is the active-low chip select.
// - Reduced variant keeps only the fourth pin, present when master clear is off.
// - Data register bits 7..4 read zero; bit 3 shows fourth pin if enabled.
package port_e_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_DATA  = 8'h00;
    localparam logic [7:0] ADDR_LATCH     = 8'h04;
    localparam logic [7:0] ADDR_DIR_STAT  = 8'h08;
    localparam logic [7:0] ADDR_IN_WORD   = 8'h0c;
    localparam logic [7:0] ADDR_OUT_WORD  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_IN_FULL    = 7;
    localparam int BIT_OUT_PEND   = 6;
    localparam int BIT_OVERRUN    = 5;
    localparam int BIT_CLIENT_EN  = 4;
    localparam int BIT_FOURTH_PIN = 3;
    localparam int BIT_RD_STROBE  = 0;
    localparam int BIT_WR_STROBE  = 1;
    localparam int BIT_CS_STROBE  = 2;
    localparam logic [2:0] DIR_RESET   = 3'h7;
    localparam logic [2:0] LATCH_RESET = 3'h0;
    localparam logic [7:0] WORD_RESET  = 8'h00;

    // Interrupt status layout
    localparam int IRQ_WRITE_DONE = 0;
    localparam int IRQ_READ_DONE  = 1;
    localparam int IRQ_OVERRUN    = 2;
    localparam int IRQ_W          = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } strobe_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } client_e;

endpackage

/* tb/port_e_io_checker.sv */
// Port-level assertions for the four-pin port block
`timescale 1ns/10ps
`default_nettype none
module port_e_io_checker (
    input wire logic        pclk,                    // Clock
    input wire logic        presetn,                 // Reset, low
    input wire logic        psel,                    // Select
    input wire logic        penable,                 // Access
    input wire logic        pwrite,                  // Direction
    input wire logic [7:0]  paddr,                   // Address
    input wire logic [31:0] pwdata,                  // Write data
    input wire logic [31:0] prdata,                  // Read data
    input wire logic        pslverr,                 // Error
    input wire logic [2:0]  pin_in,                  // Pin levels
    input wire logic [2:0]  pin_out,                 // Pin values
    input wire logic [2:0]  pin_oe,                  // Pin enables
    input wire logic [2:0]  analog_sel,              // Analog select
    input wire logic        input_only_pin,          // Fourth pin
    input wire logic        master_clear_pin_select, // Config
    input wire logic        master_clear_n,          // Master clear
    input wire logic        client_data_oe           // Bus drive
);
    wire logic rd_acc;
    wire logic wr_acc;
    assign rd_acc = psel && penable && !pwrite;
    assign wr_acc = psel && penable && pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_latch_write;
        wr_acc && (paddr == port_e_pkg::ADDR_LATCH) |=> pin_out == $past(pwdata[2:0]);
    endproperty
    property p_dir_write;
        wr_acc && (paddr == port_e_pkg::ADDR_DIR_STAT) |=> pin_oe == ~$past(pwdata[2:0]);
    endproperty
    property p_oe_cause;
        $changed(pin_oe) |-> $past(wr_acc && (paddr == port_e_pkg::ADDR_DIR_STAT));
    endproperty
    property p_pin_read;
        rd_acc && (paddr == port_e_pkg::ADDR_PIN_DATA) |-> prdata == {28'h0,
            !$past(master_clear_pin_select) && $past(input_only_pin),
            $past(pin_in) & ~$past(analog_sel)};
    endproperty
    property p_latch_read;
        rd_acc && (paddr == port_e_pkg::ADDR_LATCH) |-> prdata == {29'h0, $past(pin_out)};
    endproperty
    property p_dir_read;
        rd_acc && (paddr == port_e_pkg::ADDR_DIR_STAT) |-> !prdata[3] && prdata[31:8] == 24'h0;
    endproperty
    property p_mclr;
        master_clear_n == !(master_clear_pin_select && !input_only_pin);
    endproperty
    property p_bus_cause;
        client_data_oe |-> $past(!pin_in[0] && !pin_in[2]) && pin_oe == 3'h0;
    endproperty
    property p_unmapped;
        psel && penable && paddr > port_e_pkg::ADDR_IRQ_MASK |-> pslverr;
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write lost");
    a_dir_write: assert property (p_dir_write) else $error("enable not from dir");
    a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
    a_pin_read: assert property (p_pin_read) else $error("pin data read wrong");
    a_latch_read: assert property (p_latch_read) else $error("latch read wrong");
    a_dir_read: assert property (p_dir_read) else $error("reserved bits set");
    a_mclr: assert property (p_mclr) else $error("master clear wrong");
    a_bus_cause: assert property (p_bus_cause) else $error("bus drive no strobe");
    a_unmapped: assert property (p_unmapped) else $error("no error on hole");
    c_latch: cover property (wr_acc && paddr == port_e_pkg::ADDR_LATCH);
    c_bus: cover property (client_data_oe);
    c_err: cover property (pslverr);
endmodule
`default_nettype wire

/* tb/port_e_client_model.sv */
// External party: pin levels and client strobes
`timescale 1ns/10ps
`default_nettype none
module port_e_client_model (
    input  wire logic       pclk,            // Clock
    input  wire logic [2:0] pin_out,         // Device pin values
    input  wire logic [2:0] pin_oe,          // Device pin enables
    input  wire logic [7:0] client_data_out, // Device bus data
    input  wire logic       client_data_oe,  // Device bus drive
    output logic      [2:0] pin_in,          // Resolved pin levels
    output logic      [7:0] client_data_in   // Bus data to device
);
    // Bit 2 chip select, bit 1 write, bit 0 read; idle high
    logic [2:0] drv    = 3'h7;
    logic [7:0] wdata  = 8'h00;
    logic       wdrive = 1'b0;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
    // Released bus shows the inverse, not a stale word
    assign client_data_in = wdrive ? wdata : ~wdata;
    task automatic ext_write(input logic [7:0] d, input int slow);
        @(posedge pclk);
        wdata  <= d;
        wdrive <= 1'b1;
        drv    <= 3'b001;
        repeat (1 + slow) @(posedge pclk);
        drv <= 3'h7;
        @(posedge pclk);
        wdrive <= 1'b0;
    endtask
    task automatic ext_read(output logic [7:0] d, output logic oe, input int slow);
        @(posedge pclk);
        drv <= 3'b010;
        repeat (2 + slow) @(posedge pclk);
        d  = client_data_out;
        oe = client_data_oe;
        drv <= 3'h7;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

/* tb/four_bit_port_e_io_tb.sv */
// Self-checking bench for the four-pin port block
`timescale 1ns/10ps
`default_nettype none
module four_bit_port_e_io_tb;
    typedef struct packed {
        logic [2:0] dir, lat, lvl, ana;
        logic       io, mcs, mc_n;
        logic [7:0] exp_rd;
    } row_s;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        pready, pslverr, slv, master_clear_n, client_data_oe, irq, rd_oe;
    logic [2:0]  pin_in, pin_out, pin_oe;
    logic [2:0]  analog_sel = 3'h7;
    logic        input_only_pin = 1'b1;
    logic        master_clear_pin_select = 1'b0;
    logic [7:0]  client_data_in, client_data_out, rd_word;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    row_s        rows [5] = '{
        '{3'h7, 3'h0, 3'h5, 3'h0, 1'b1, 1'b0, 1'b1, 8'h0d},
        '{3'h0, 3'h6, 3'h1, 3'h0, 1'b0, 1'b0, 1'b1, 8'h06},
        '{3'h7, 3'h3, 3'h7, 3'h7, 1'b1, 1'b1, 1'b1, 8'h00},
        '{3'h4, 3'h3, 3'h6, 3'h1, 1'b1, 1'b0, 1'b1, 8'h0e},
        '{3'h0, 3'h5, 3'h0, 3'h7, 1'b0, 1'b1, 1'b0, 8'h00}};
    port_e_io #(.FULL_PORT(1), .DATA_W(8)) i_port_e_io (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .analog_sel(analog_sel),
        .input_only_pin(input_only_pin), .master_clear_pin_select(master_clear_pin_select),
        .master_clear_n(master_clear_n), .client_data_in(client_data_in),
        .client_data_out(client_data_out), .client_data_oe(client_data_oe), .irq(irq));
    port_e_client_model i_port_e_client_model (
        .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .client_data_out(client_data_out),
        .client_data_oe(client_data_oe), .pin_in(pin_in), .client_data_in(client_data_in));
    always #5 pclk = ~pclk;
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        slv   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk({29'h0, pin_oe}, 32'h0);
        chk({29'h0, pin_out}, 32'h0);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h07);
        rd(port_e_pkg::ADDR_PIN_DATA, 32'h08);
        foreach (rows[i]) begin
            analog_sel <= rows[i].ana;
            input_only_pin <= rows[i].io;
            master_clear_pin_select <= rows[i].mcs;
            i_port_e_client_model.drv <= rows[i].lvl;
            apb(1'b1, port_e_pkg::ADDR_DIR_STAT, {29'h0, rows[i].dir});
            apb(1'b1, port_e_pkg::ADDR_LATCH, {29'h0, rows[i].lat});
            @(posedge pclk);
            chk({29'h0, pin_oe}, {29'h0, ~rows[i].dir});
            chk({29'h0, pin_out}, {29'h0, rows[i].lat});
            chk({31'h0, master_clear_n}, {31'h0, rows[i].mc_n});
            rd(port_e_pkg::ADDR_PIN_DATA, {24'h0, rows[i].exp_rd});
            rd(port_e_pkg::ADDR_LATCH, {29'h0, rows[i].lat});
        end
        i_port_e_client_model.drv <= 3'h7;
        analog_sel <= 3'h0;
        apb(1'b1, port_e_pkg::ADDR_DIR_STAT, 32'hff);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h17);
        rd(8'h1c, 32'h0);
        chk({31'h0, slv}, 32'h1);
        apb(1'b1, port_e_pkg::ADDR_IRQ_MASK, 32'h7);
        i_port_e_client_model.ext_write(8'ha5, 0);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h97);
        chk({31'h0, irq}, 32'h1);
        i_port_e_client_model.ext_write(8'h3c, 2);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'hb7);
        rd(port_e_pkg::ADDR_IN_WORD, 32'h3c);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h37);
        apb(1'b1, port_e_pkg::ADDR_DIR_STAT, 32'h17);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h17);
        i_port_e_client_model.drv <= 3'b101;
        repeat (3) @(posedge pclk);
        i_port_e_client_model.drv <= 3'h7;
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h17);
        rd(port_e_pkg::ADDR_IRQ_STAT, 32'h05);
        rd(port_e_pkg::ADDR_IRQ_STAT, 32'h00);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, port_e_pkg::ADDR_IRQ_MASK, 32'h0);
        apb(1'b1, port_e_pkg::ADDR_OUT_WORD, 32'h5a);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h57);
        i_port_e_client_model.ext_read(rd_word, rd_oe, 1);
        chk({24'h0, rd_word}, 32'h5a);
        chk({31'h0, rd_oe}, 32'h1);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h17);
        chk({31'h0, irq}, 32'h0);
        rd(port_e_pkg::ADDR_IRQ_STAT, 32'h02);
        apb(1'b1, port_e_pkg::ADDR_DIR_STAT, 32'h16);
        i_port_e_client_model.ext_write(8'h77, 0);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h16);
        apb(1'b1, port_e_pkg::ADDR_DIR_STAT, 32'h07);
        i_port_e_client_model.ext_write(8'h77, 0);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h07);
        apb(1'b1, port_e_pkg::ADDR_PIN_DATA, 32'h3);
        rd(port_e_pkg::ADDR_LATCH, 32'h3);
        apb(1'b1, port_e_pkg::ADDR_DIR_STAT, 32'h0);
        // Mid-run reset must float the pins and clear the latch
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({29'h0, pin_oe}, 32'h0);
        presetn <= 1'b1;
        rd(port_e_pkg::ADDR_LATCH, 32'h0);
        rd(port_e_pkg::ADDR_DIR_STAT, 32'h07);
        end_of_test();
    end
endmodule
bind port_e_io port_e_io_checker i_port_e_io_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .analog_sel(analog_sel),
    .input_only_pin(input_only_pin), .master_clear_pin_select(master_clear_pin_select),
    .master_clear_n(master_clear_n), .client_data_oe(client_data_oe));
`default_nettype wire
